// [ads_pkg.sv]
/*
 package of the amplifier control link: bit positions, thresholds,
 register offsets and link timing shared by both ends.
 assumes a 20 MHz pclk on both ends.
*/
package ads_pkg;
   // ----------------------------------------
   // clock and link timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int SCL_QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
   // host software waits, kept here for the driver writer
   localparam int TON_DIAG_WAIT_MS = 200;
   localparam int OFFSET_DET_WAIT_MS = 30;

   // ----------------------------------------
   // link framing
   // ----------------------------------------
   // arbitrary 7-bit device address
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h6c;
   localparam int NUM_WR_BYTES = 2;
   localparam int NUM_STATUS_BYTES = 4;

   // ----------------------------------------
   // instruction and status bit positions
   // ----------------------------------------
   localparam int INSTR_ONE_STANDBY_BIT = 4;
   localparam int INSTR_ONE_OFFSET_EN_BIT = 5;
   localparam int INSTR_ONE_DIAG_EN_BIT = 6;
   localparam int INSTR_TWO_CUR_SEL_BIT = 7;
   localparam int SB2_OFFSET_ACT_BIT = 7;
   localparam int SB3_STANDBY_BIT = 7;
   localparam int SB3_DIAG_BIT = 6;
   localparam int SB4_TWARN2_BIT = 7;
   localparam int SB4_TWARN3_BIT = 6;
   localparam int SB4_OPEN_BIT = 5;
   localparam int SB4_PERM_BIT = 4;
   localparam int SB4_SHORT_BIT = 3;
   localparam int SB4_OL_OFS_BIT = 2;
   localparam int SB4_VCC_BIT = 1;
   localparam int SB4_GND_BIT = 0;

   // ----------------------------------------
   // open-load current thresholds in mA
   // ----------------------------------------
   localparam logic [11:0] OPEN_LO_NORM_MA = 12'h12c;
   localparam logic [11:0] OPEN_HI_NORM_MA = 12'h1f4;
   localparam logic [11:0] OPEN_LO_SENS_MA = 12'h07d;
   localparam logic [11:0] OPEN_HI_SENS_MA = 12'h0fa;

   // ----------------------------------------
   // host apb registers
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_RESULT = 8'h0c;
   localparam int CTRL_GO_BIT = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_NACK_BIT = 1;
endpackage

// [ads_if.sv]
/*
 two-wire link between host and amplifier ends.
 assumes pull-ups: a line is low only while some end enables a low drive.
*/
`timescale 1ns/100ps
interface ads_if;
   logic host_scl_o;
   logic host_scl_oe;
   logic host_sda_o;
   logic host_sda_oe;
   logic dev_sda_o;
   logic dev_sda_oe;
   logic scl;
   logic sda;

   // wired-and of the open-drain drivers
   assign scl = !(host_scl_oe && !host_scl_o);
   assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

   modport host (output host_scl_o, output host_scl_oe, output host_sda_o,
      output host_sda_oe, input scl, input sda);
   modport dev (output dev_sda_o, output dev_sda_oe, input scl, input sda);
endinterface

// [ads_dev.sv]
/*
 amplifier end of the control link: two-wire slave that takes two
 instruction bytes and returns four diagnostic status bytes.
 assumes diagnostic inputs come from logic on pclk; link pins are async.
*/
`timescale 1ns/100ps
// Behaviour
// - status four bit 7 is thermal warning two
// - status four bit 6 is thermal warning three
// - normal threshold: open below 300, normal above 500
// - sensitive threshold: open below 125, normal above 250
// - bit 4 gives turn-on or permanent source
// - bit 3 flags shorted second-channel load
// - bit 2 open load or offset by mode
// - bit 1 flags short to supply
// - bit 0 flags short to ground
// - write: address, two instruction bytes, all acknowledged
// - read: address, four status bytes, master acks
// - host waits 200 ms before reading diagnostics
// - amplifier on: fixed instruction byte patterns
// - amplifier off: clear turn-on bit
// - offset detection start: fixed instruction patterns
// - offset read: only bit 2 valid
// - host waits 30 ms before stopping offset
// - status two bit 7 shows offset active
// - status three mirrors diagnostic and standby bits
module ads_dev #(
   parameter logic [6:0] DEV_ADDR = ads_pkg::DEV_ADDR_DEFAULT
) (
   input wire logic pclk,
   input wire logic presetn,
   ads_if.dev link,
   input wire logic thermal_warn_two,
   input wire logic thermal_warn_three,
   input wire logic [11:0] second_channel_peak_ma,
   input wire logic second_channel_permanent,
   input wire logic second_channel_short_load,
   input wire logic second_channel_open_turn_on,
   input wire logic second_channel_offset,
   input wire logic second_channel_short_vcc,
   input wire logic second_channel_short_gnd,
   input wire logic [7:0] status_byte_one,
   input wire logic [6:0] status_byte_two_low,
   input wire logic [5:0] status_byte_three_low,
   output logic [7:0] instruction_byte_one,
   output logic [7:0] instruction_byte_two,
   output logic command_strobe
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [2:0] {
      DS_IDLE, DS_ADDR, DS_AACK, DS_WDATA, DS_WACK, DS_RDATA, DS_RACK
   } ads_dstate_t;

   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_prev;
      logic sda_prev;
      ads_dstate_t fsm;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [1:0] idx;
      logic rd;
      logic wrote;
      logic mack;
      logic open_load;
      logic [7:0] ib1;
      logic [7:0] ib2;
      logic strobe;
      logic sda_oe;
   } ads_dev_state_t;

   ads_dev_state_t s_ff;
   ads_dev_state_t nxt_s;

   logic scl_now;
   logic sda_now;
   logic rise;
   logic fall;
   logic start_cond;
   logic stop_cond;
   logic [7:0] sb2;
   logic [7:0] sb3;
   logic [7:0] sb4;
   logic [11:0] lo_ma;
   logic [11:0] hi_ma;

   // ----------------------------------------
   // line events, read only from second sync stage
   // ----------------------------------------
   assign scl_now = s_ff.scl_sync[1];
   assign sda_now = s_ff.sda_sync[1];
   assign rise = scl_now && !s_ff.scl_prev;
   assign fall = !scl_now && s_ff.scl_prev;
   assign start_cond = scl_now && s_ff.scl_prev && s_ff.sda_prev && !sda_now;
   assign stop_cond = scl_now && s_ff.scl_prev && !s_ff.sda_prev && sda_now;

   // ----------------------------------------
   // status bytes
   // ----------------------------------------
   assign lo_ma = s_ff.ib2[ads_pkg::INSTR_TWO_CUR_SEL_BIT] ? ads_pkg::OPEN_LO_SENS_MA
                                                      : ads_pkg::OPEN_LO_NORM_MA;
   assign hi_ma = s_ff.ib2[ads_pkg::INSTR_TWO_CUR_SEL_BIT] ? ads_pkg::OPEN_HI_SENS_MA
                                                      : ads_pkg::OPEN_HI_NORM_MA;

   always_comb begin
      sb2 = {1'b0, status_byte_two_low};
      sb2[ads_pkg::SB2_OFFSET_ACT_BIT] = s_ff.ib1[ads_pkg::INSTR_ONE_OFFSET_EN_BIT];
      sb3 = {2'b00, status_byte_three_low};
      sb3[ads_pkg::SB3_STANDBY_BIT] = s_ff.ib1[ads_pkg::INSTR_ONE_STANDBY_BIT];
      sb3[ads_pkg::SB3_DIAG_BIT] = s_ff.ib1[ads_pkg::INSTR_ONE_DIAG_EN_BIT];
      sb4 = 8'h00;
      sb4[ads_pkg::SB4_TWARN2_BIT] = thermal_warn_two;
      sb4[ads_pkg::SB4_TWARN3_BIT] = thermal_warn_three;
      sb4[ads_pkg::SB4_OPEN_BIT] = s_ff.open_load;
      sb4[ads_pkg::SB4_PERM_BIT] = second_channel_permanent;
      sb4[ads_pkg::SB4_SHORT_BIT] = second_channel_short_load;
      sb4[ads_pkg::SB4_OL_OFS_BIT] = second_channel_permanent ? second_channel_offset
                                                     : second_channel_open_turn_on;
      sb4[ads_pkg::SB4_VCC_BIT] = second_channel_short_vcc;
      sb4[ads_pkg::SB4_GND_BIT] = second_channel_short_gnd;
   end

   function automatic logic [7:0] pick(input logic [1:0] i, input logic [7:0] b2,
                                       input logic [7:0] b3, input logic [7:0] b4);
      logic [7:0] r;
      r = status_byte_one;
      unique case (i)
         2'h0: r = status_byte_one;
         2'h1: r = b2;
         2'h2: r = b3;
         2'h3: r = b4;
      endcase
      return r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.scl_sync = {s_ff.scl_sync[0], link.scl};
      nxt_s.sda_sync = {s_ff.sda_sync[0], link.sda};
      nxt_s.scl_prev = scl_now;
      nxt_s.sda_prev = sda_now;
      nxt_s.strobe = 1'b0;

      // open-load with hysteresis between the two thresholds
      if (second_channel_peak_ma < lo_ma) begin
         nxt_s.open_load = 1'b1;
      end else if (second_channel_peak_ma > hi_ma) begin
         nxt_s.open_load = 1'b0;
      end

      if (stop_cond) begin
         if (s_ff.wrote) begin
            nxt_s.strobe = 1'b1;
         end
         nxt_s.wrote = 1'b0;
         nxt_s.sda_oe = 1'b0;
         nxt_s.fsm = DS_IDLE;
      end else if (start_cond) begin
         nxt_s.sda_oe = 1'b0;
         nxt_s.cnt = 4'h0;
         nxt_s.fsm = DS_ADDR;
      end else begin
         unique case (s_ff.fsm)
            DS_IDLE: begin
            end
            DS_ADDR, DS_WDATA: begin
               if (rise) begin
                  nxt_s.sh = {s_ff.sh[6:0], sda_now};
                  nxt_s.cnt = s_ff.cnt + 4'h1;
               end else if (fall && s_ff.cnt == 4'h8) begin
                  if (s_ff.fsm == DS_WDATA) begin
                     nxt_s.sda_oe = 1'b1;
                     nxt_s.fsm = DS_WACK;
                     // every bit stored as sent; no field is filtered
                     if (s_ff.idx == 2'h0) begin
                        nxt_s.ib1 = s_ff.sh;
                     end else if (s_ff.idx == 2'h1) begin
                        nxt_s.ib2 = s_ff.sh;
                     end
                     if (s_ff.idx < 2'(ads_pkg::NUM_WR_BYTES)) begin
                        nxt_s.idx = s_ff.idx + 2'h1;
                        nxt_s.wrote = 1'b1;
                     end
                  end else if (s_ff.sh[7:1] == DEV_ADDR) begin
                     nxt_s.sda_oe = 1'b1;
                     nxt_s.rd = s_ff.sh[0];
                     nxt_s.idx = 2'h0;
                     nxt_s.fsm = DS_AACK;
                  end else begin
                     nxt_s.fsm = DS_IDLE;
                  end
               end
            end
            DS_AACK: begin
               if (fall) begin
                  nxt_s.cnt = 4'h0;
                  if (s_ff.rd) begin
                     nxt_s.sh = pick(2'h0, sb2, sb3, sb4);
                     nxt_s.sda_oe = !nxt_s.sh[7];
                     nxt_s.fsm = DS_RDATA;
                  end else begin
                     nxt_s.sda_oe = 1'b0;
                     nxt_s.fsm = DS_WDATA;
                  end
               end
            end
            DS_WACK: begin
               if (fall) begin
                  nxt_s.sda_oe = 1'b0;
                  nxt_s.cnt = 4'h0;
                  nxt_s.fsm = DS_WDATA;
               end
            end
            DS_RDATA: begin
               if (fall) begin
                  if (s_ff.cnt == 4'h7) begin
                     nxt_s.sda_oe = 1'b0;
                     nxt_s.fsm = DS_RACK;
                  end else begin
                     nxt_s.cnt = s_ff.cnt + 4'h1;
                     nxt_s.sh = {s_ff.sh[6:0], 1'b0};
                     nxt_s.sda_oe = !s_ff.sh[6];
                  end
               end
            end
            DS_RACK: begin
               if (rise) begin
                  nxt_s.mack = !sda_now;
               end else if (fall) begin
                  // stop sending after the fourth byte so the master can stop
                  if (s_ff.mack && s_ff.idx != 2'(ads_pkg::NUM_STATUS_BYTES - 1)) begin
                     nxt_s.idx = s_ff.idx + 2'h1;
                     nxt_s.sh = pick(s_ff.idx + 2'h1, sb2, sb3, sb4);
                     nxt_s.sda_oe = !nxt_s.sh[7];
                     nxt_s.cnt = 4'h0;
                     nxt_s.fsm = DS_RDATA;
                  end else begin
                     nxt_s.fsm = DS_IDLE;
                  end
               end
            end
            default: nxt_s.fsm = DS_IDLE;
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_prev: 1'b1, sda_prev: 1'b1,
                   fsm: DS_IDLE, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign link.dev_sda_o = 1'b0;
   assign link.dev_sda_oe = s_ff.sda_oe;
   assign instruction_byte_one = s_ff.ib1;
   assign instruction_byte_two = s_ff.ib2;
   assign command_strobe = s_ff.strobe;
endmodule

// [ads_host.sv]
/*
 host end of the control link: apb slave registers steer a two-wire
 master that writes two instruction bytes or reads four status bytes.
 assumes the device never stretches the serial clock.
*/
`timescale 1ns/100ps
module ads_host #(
   parameter logic [6:0] DEV_ADDR = ads_pkg::DEV_ADDR_DEFAULT,
   parameter int QTR_CYC = ads_pkg::SCL_QTR_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   ads_if.host link,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   // elaboration check on the quarter-period count
   if (QTR_CYC < 4 || QTR_CYC > 65535) begin
      $error("QTR_CYC out of range");
   end

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} ads_hstate_t;

   typedef struct packed {
      logic [1:0] sda_sync;
      ads_hstate_t fsm;
      logic [1:0] ph;
      logic [15:0] qcnt;
      logic [2:0] bi;
      logic [3:0] k;
      logic [7:0] tx;
      logic [7:0] rx;
      logic rd;
      logic busy;
      logic nack;
      logic [15:0] cmd;
      logic [31:0] result;
      logic scl_oe;
      logic sda_oe;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ads_host_state_t;

   ads_host_state_t s_ff;
   ads_host_state_t nxt_s;
   logic tick;
   logic setup;
   logic rx_byte;
   logic [2:0] last_bi;

   assign tick = s_ff.qcnt == 16'(QTR_CYC - 1);
   assign setup = psel && !penable;
   assign rx_byte = s_ff.rd && s_ff.bi != 3'h0;
   assign last_bi = s_ff.rd ? 3'(ads_pkg::NUM_STATUS_BYTES) : 3'(ads_pkg::NUM_WR_BYTES);

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      nxt_s = s_ff;
      nxt_s.sda_sync = {s_ff.sda_sync[0], link.sda};
      nxt_s.pready = setup;
      nxt_s.pslverr = 1'b0;

      // apb slave: answer in the first access cycle
      if (setup) begin
         nxt_s.prdata = 32'h0000_0000;
         unique case (paddr)
            ads_pkg::REG_CTRL: begin
               if (pwrite && !s_ff.busy && pwdata[ads_pkg::CTRL_GO_BIT]) begin
                  nxt_s.rd = pwdata[ads_pkg::CTRL_READ_BIT];
                  nxt_s.busy = 1'b1;
                  nxt_s.nack = 1'b0;
                  nxt_s.fsm = HS_START;
                  nxt_s.ph = 2'h0;
                  nxt_s.qcnt = 16'h0000;
               end
            end
            ads_pkg::REG_CMD: begin
               // command patterns pass through untouched
               if (pwrite && !s_ff.busy) begin
                  nxt_s.cmd = pwdata[15:0];
               end
               nxt_s.prdata = {16'h0000, s_ff.cmd};
            end
            ads_pkg::REG_STAT: begin
               nxt_s.prdata[ads_pkg::STAT_BUSY_BIT] = s_ff.busy;
               nxt_s.prdata[ads_pkg::STAT_NACK_BIT] = s_ff.nack;
            end
            ads_pkg::REG_RESULT: begin
               nxt_s.prdata = s_ff.result;
            end
            default: begin
               nxt_s.pslverr = 1'b1;
            end
         endcase
      end

      // two-wire master, four quarter phases per bit
      if (s_ff.fsm != HS_IDLE) begin
         nxt_s.qcnt = tick ? 16'h0000 : s_ff.qcnt + 16'h0001;
      end
      if (tick) begin
         nxt_s.ph = s_ff.ph + 2'h1;
         unique case (s_ff.fsm)
            HS_IDLE: begin
            end
            HS_START: begin
               if (s_ff.ph == 2'h1) begin
                  nxt_s.sda_oe = 1'b1;
               end else if (s_ff.ph == 2'h2) begin
                  nxt_s.scl_oe = 1'b1;
                  nxt_s.fsm = HS_BIT;
                  nxt_s.ph = 2'h0;
                  nxt_s.bi = 3'h0;
                  nxt_s.k = 4'h0;
                  nxt_s.tx = {DEV_ADDR, s_ff.rd};
               end
            end
            HS_BIT: begin
               if (s_ff.ph == 2'h0) begin
                  if (s_ff.k == 4'h8) begin
                     // master acks every status byte, including the fourth
                     nxt_s.sda_oe = rx_byte;
                  end else begin
                     nxt_s.sda_oe = !rx_byte && !s_ff.tx[7];
                  end
               end else if (s_ff.ph == 2'h1) begin
                  nxt_s.scl_oe = 1'b0;
               end else if (s_ff.ph == 2'h2) begin
                  if (s_ff.k == 4'h8 && !rx_byte && s_ff.sda_sync[1]) begin
                     nxt_s.nack = 1'b1;
                  end
                  if (s_ff.k != 4'h8) begin
                     nxt_s.rx = {s_ff.rx[6:0], s_ff.sda_sync[1]};
                     nxt_s.tx = {s_ff.tx[6:0], 1'b0};
                  end
               end else begin
                  nxt_s.scl_oe = 1'b1;
                  nxt_s.k = s_ff.k + 4'h1;
                  if (s_ff.k == 4'h8) begin
                     nxt_s.k = 4'h0;
                     nxt_s.bi = s_ff.bi + 3'h1;
                     nxt_s.tx = s_ff.bi == 3'h0 ? s_ff.cmd[7:0] : s_ff.cmd[15:8];
                     if (rx_byte) begin
                        nxt_s.result[8 * (32'(s_ff.bi) - 1) +: 8] = s_ff.rx;
                     end
                     if (s_ff.nack || s_ff.bi == last_bi) begin
                        nxt_s.fsm = HS_STOP;
                     end
                  end
               end
            end
            HS_STOP: begin
               if (s_ff.ph == 2'h0) begin
                  nxt_s.sda_oe = 1'b1;
               end else if (s_ff.ph == 2'h1) begin
                  nxt_s.scl_oe = 1'b0;
               end else if (s_ff.ph == 2'h2) begin
                  nxt_s.sda_oe = 1'b0;
               end else begin
                  nxt_s.fsm = HS_IDLE;
                  nxt_s.busy = 1'b0;
                  nxt_s.qcnt = 16'h0000;
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_ff <= '{sda_sync: 2'h3, fsm: HS_IDLE, default: '0};
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign link.host_scl_o = 1'b0;
   assign link.host_scl_oe = s_ff.scl_oe;
   assign link.host_sda_o = 1'b0;
   assign link.host_sda_oe = s_ff.sda_oe;
   assign prdata = s_ff.prdata;
   assign pready = s_ff.pready;
   assign pslverr = s_ff.pslverr;
endmodule

// [ads_sva.sv]
/*
 checker of the amplifier control link and the host register port.
 assumes instantiation beside the link interface, all on pclk.
*/
`timescale 1ns/100ps
module ads_sva (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic host_scl_oe,
   input wire logic host_sda_oe,
   input wire logic dev_sda_oe,
   input wire logic scl,
   input wire logic sda,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic command_strobe
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // link framing
   // ----------------------------------------
   sequence start_cond;
      scl && $fell(sda) && host_sda_oe;
   endsequence
   sequence stop_cond;
      scl && $rose(sda);
   endsequence
   a_reset_idle: assert property ($rose(presetn) |-> !host_scl_oe && !host_sda_oe && !dev_sda_oe)
      else $error("link not idle after reset");
   a_start_then_clock: assert property (start_cond |-> ##[1:40] !scl)
      else $error("no clock after start");
   a_stop_released: assert property (stop_cond |->
      $past(host_sda_oe) && !host_sda_oe && !dev_sda_oe)
      else $error("data line driven at stop");
   a_dev_sda_hold: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
      else $error("device changed data while clock high");
   a_scl_high_min: assert property ($rose(scl) |-> scl [*4])
      else $error("clock high phase too short");
   a_strobe_single: assert property (command_strobe |=> !command_strobe)
      else $error("command strobe longer than one cycle");
   a_strobe_idle_bus: assert property (command_strobe |-> scl && sda)
      else $error("command strobe before stop");
   // ----------------------------------------
   // register port
   // ----------------------------------------
   a_apb_zero_wait: assert property (psel && !penable |=> pready)
      else $error("ready missing in access cycle");
   a_ready_single: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
endmodule

// [tb.sv]
/*
 testbench: host and amplifier ends joined by the link interface.
 assumes a 20 MHz pclk and a short link quarter period for speed.
*/
`timescale 1ns/100ps
module tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, strobe, perr;
   logic [7:0] paddr, ib1, ib2, dv, e1, e2;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] peak;
   int failures, total_checks, cyc, strobes, n;
   logic [7:0] dvs[10] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h24, 8'h28};
   logic [12:0] hys[8] = '{13'h012b, 13'h01f4, 13'h01f5, 13'h012c,
      13'h10f9, 13'h107c, 13'h10fa, 13'h10fb};
   logic hol[8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
   ads_if link_if();
   ads_host #(.QTR_CYC(4)) ads_host_inst (.pclk(pclk), .presetn(presetn), .link(link_if.host),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ads_dev ads_dev_inst (.pclk(pclk), .presetn(presetn), .link(link_if.dev),
      .thermal_warn_two(dv[7]), .thermal_warn_three(dv[6]), .second_channel_peak_ma(peak),
      .second_channel_permanent(dv[5]), .second_channel_short_load(dv[4]),
      .second_channel_open_turn_on(dv[3]), .second_channel_offset(dv[2]),
      .second_channel_short_vcc(dv[1]), .second_channel_short_gnd(dv[0]),
      .status_byte_one(8'ha5), .status_byte_two_low(7'h2a), .status_byte_three_low(6'h15),
      .instruction_byte_one(ib1), .instruction_byte_two(ib2), .command_strobe(strobe));
   ads_sva ads_sva_inst (.pclk(pclk), .presetn(presetn), .host_scl_oe(link_if.host_scl_oe),
      .host_sda_oe(link_if.host_sda_oe), .dev_sda_oe(link_if.dev_sda_oe), .scl(link_if.scl),
      .sda(link_if.sda), .psel(psel), .penable(penable), .pready(pready),
      .command_strobe(strobe));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (strobe === 1'b1) strobes++;
      if (cyc == 90000) begin
         failures++;
         report_and_stop();
      end
   end
   task report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // ----------------------------------------
   // one link frame: write or read, then wait idle
   // ----------------------------------------
   task frame(input logic rdop);
      apb(1'b1, ads_pkg::REG_CMD, {16'h0000, e2, e1});
      apb(1'b1, ads_pkg::REG_CTRL, {30'h0, rdop, 1'b1});
      do apb(1'b0, ads_pkg::REG_STAT, 32'h0); while (rd[ads_pkg::STAT_BUSY_BIT] !== 1'b0);
      chk("nack", 32'h0, {31'h0, rd[ads_pkg::STAT_NACK_BIT]});
   endtask
   task wr(input logic [7:0] a, input logic [7:0] b);
      n = strobes;
      e1 = a;
      e2 = b;
      frame(1'b0);
      chk("instruction one", {24'h0, e1}, {24'h0, ib1});
      chk("instruction two", {24'h0, e2}, {24'h0, ib2});
      chk("strobes", n + 1, strobes);
   endtask
   task rdst(input logic ol);
      repeat (4) @(posedge pclk);
      frame(1'b1);
      apb(1'b0, ads_pkg::REG_RESULT, 32'h0);
      chk("status", {dv[7:6], ol, dv[5:4], dv[5] ? dv[2] : dv[3], dv[1:0],
         e1[4], e1[6], 6'h15, e1[5], 7'h2a, 8'ha5}, rd);
   endtask
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, dv} = '0;
      peak = 12'h258;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h10, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, perr});
      apb(1'b0, ads_pkg::REG_STAT, 32'h0);
      chk("stat reset", 32'h0, rd);
      wr(8'h40, 8'h00);
      rdst(1'b0);
      $display("test turn-on diagnostic done");
      for (int i = 0; i < 10; i++) begin
         dv <= dvs[i];
         rdst(1'b0);
      end
      dv <= 8'h00;
      $display("test status byte four done");
      for (int i = 0; i < 8; i++) begin
         peak <= hys[i][11:0];
         wr(8'h40, {hys[i][12], 7'h00});
         rdst(hol[i]);
      end
      peak <= 12'h258;
      $display("test open-load thresholds done");
      wr(8'h00, 8'h13);
      wr(8'h00, 8'h00);
      wr(8'h26, 8'h10);
      rdst(1'b0);
      $display("test command sequences done");
      report_and_stop();
   end
endmodule
